//--- bench/gdcr_bank_assertions.sv
// assertion checker for the gate drive direct control bank
module gdcr_chk (
  input wire logic clk_sys, // clock
  input wire logic srst, // reset
  input wire logic reg_rd, // read strobe
  input wire logic reg_rvalid_q, // read valid
  input wire logic global_driver_enable, // driver enable
  input wire logic [2:0] pwm_mode, // mode field
  input wire logic [2:0] pwm_high, // upper demand
  input wire logic [2:0] pwm_low, // lower demand
  input wire logic [5:0] upper_sink_code, // upper sink code
  input wire logic [1:0] upper_ratio, // upper ratio
  input wire logic upper_gate_out_a, // gate
  input wire logic upper_gate_out_b, // gate
  input wire logic upper_gate_out_c, // gate
  input wire logic lower_gate_out_a, // gate
  input wire logic lower_gate_out_b, // gate
  input wire logic lower_gate_out_c, // gate
  input wire logic [2:0] phase_pulldown, // pull-down flags
  input wire logic [5:0] upper_source_code_q, // upper source code
  input wire logic upper_ratio_used_q, // ratio used flag
  input wire logic [1:0] upper_ratio_q // ratio in effect
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  read_answer_a: assert property (reg_rd |=> reg_rvalid_q) else $error("no read answer");
  valid_cause_a: assert property (reg_rvalid_q |-> $past(reg_rd)) else $error("stray valid");
  enable_off_a: assert property (
    !global_driver_enable |=> {upper_gate_out_a, upper_gate_out_b, upper_gate_out_c,
    lower_gate_out_a, lower_gate_out_b, lower_gate_out_c, phase_pulldown} == 9'h000)
    else $error("outputs active while disabled");
  pulldown_low_a: assert property (
    (!phase_pulldown[2] || !upper_gate_out_a && !lower_gate_out_a)
    && (!phase_pulldown[1] || !upper_gate_out_b && !lower_gate_out_b)
    && (!phase_pulldown[0] || !upper_gate_out_c && !lower_gate_out_c))
    else $error("gate high while pulled");
  mode_follow_a: assert property (
    global_driver_enable && pwm_mode != 3'h5 |=> phase_pulldown[2]
    || {upper_gate_out_a, lower_gate_out_a} == {$past(pwm_high[2]), $past(pwm_low[2])})
    else $error("gate a not following mode");
  pulldown_enable_a: assert property (
    |phase_pulldown |-> $past(global_driver_enable))
    else $error("pull-down without enable");
  ratio_follow_a: assert property (
    upper_ratio_used_q |-> upper_source_code_q == $past(upper_sink_code)
    && upper_ratio_q == $past(upper_ratio) && $past(upper_sink_code) <= 6'h23)
    else $error("ratio path wrong");
  ratio_zero_a: assert property (!upper_ratio_used_q |-> upper_ratio_q == 2'h0)
    else $error("ratio shown while unused");
  cover property (global_driver_enable && pwm_mode == 3'h5 ##1 upper_gate_out_a);
  cover property (phase_pulldown[2]);
  cover property (upper_ratio_used_q);
endmodule // gdcr_chk

bind gdcr_bank gdcr_chk u_chk (.*);

//--- bench/gdcr_host.sv
// host model driving the parallel register port of the bank
module gdcr_host (
  input wire logic clk_sys, // clock
  output logic [6:0] reg_addr = 7'h00, // address
  output logic [15:0] reg_wdata = 16'h0000, // write data
  output logic reg_wr = 1'b0, // write strobe
  output logic reg_rd = 1'b0, // read strobe
  input wire logic [15:0] reg_rdata_q, // read data
  input wire logic reg_rvalid_q // read valid
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic wr(input logic [6:0] a, input logic [15:0] w);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = w;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    // released lines never keep the last value
    reg_addr = ~a;
    reg_wdata = ~w;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] r, output logic v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    // the valid pulse stands only for the cycle after the taking edge; the read data holds until the next read
    r = reg_rdata_q;
    v = reg_rvalid_q;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule // gdcr_host

//--- bench/tb.sv
// self-checking testbench for the gate drive direct control bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic en = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [2:0] ph = 3'h5;
  logic [15:0] d;
  logic v;
  int errors = 0;
  int num_checks = 0;
  wire [6:0] addr;
  wire [15:0] wdata;
  wire [15:0] rdata;
  wire wr;
  wire rd;
  wire rv;
  wire [5:0] gates;
  wire [2:0] pd;
  wire [5:0] usrc;
  wire [5:0] lsrc;
  wire [5:0] flags;
  initial begin forever #50 clk_sys = ~clk_sys; end
  gdcr_host u_host (.clk_sys(clk_sys), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata_q(rdata), .reg_rvalid_q(rv));
  gdcr_bank dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata_q(rdata), .reg_rvalid_q(rv),
    .global_driver_enable(en), .pwm_mode(mode), .pwm_high(ph), .pwm_low(ph),
    .upper_sink_code(6'h10), .lower_sink_code(6'h30), .upper_ratio(2'h2), .lower_ratio(2'h1),
    .upper_gate_out_a(gates[5]), .upper_gate_out_b(gates[4]), .upper_gate_out_c(gates[3]),
    .lower_gate_out_a(gates[2]), .lower_gate_out_b(gates[1]), .lower_gate_out_c(gates[0]),
    .phase_pulldown(pd), .upper_source_code_q(usrc), .lower_source_code_q(lsrc),
    .upper_ratio_used_q(flags[5]), .lower_ratio_used_q(flags[4]), .upper_ratio_q(flags[3:2]),
    .lower_ratio_q(flags[1:0]));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] e);
    u_host.rd(a, d, v);
    chk("rvalid", 16'h0001, {15'h0000, v});
    chk("rdata", e, d);
  endtask
  task automatic close_out;
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    srst = 1'b0;
    rchk(7'h23, 16'h0000);
    rchk(7'h24, 16'h0007);
    rchk(7'h25, 16'h0000);
    u_host.wr(7'h23, 16'hFFFF);
    rchk(7'h23, 16'h023F);
    u_host.wr(7'h24, 16'hFFFF);
    rchk(7'h24, 16'h0007);
    u_host.wr(7'h25, 16'hFFFF);
    rchk(7'h25, 16'h3F3F);
    u_host.wr(7'h26, 16'hFFFF);
    rchk(7'h26, 16'h0000);
    u_host.wr(7'h25, 16'h2A15);
    repeat (2) @(negedge clk_sys);
    chk("src_codes", 16'h2A15, {2'h0, usrc, 2'h0, lsrc});
    chk("ratio_flags", 16'h0000, {10'h000, flags});
    u_host.wr(7'h23, 16'h0000);
    repeat (2) @(negedge clk_sys);
    chk("src_codes", 16'h1030, {2'h0, usrc, 2'h0, lsrc});
    chk("ratio_flags", 16'h0028, {10'h000, flags});
    en = 1'b1;
    mode = 3'h5;
    for (int i = 0; i < 6; i++) begin
      u_host.wr(7'h23, 16'h0001 << i);
      repeat (2) @(negedge clk_sys);
      chk("gates", 16'h0001 << i, {10'h000, gates});
    end
    u_host.wr(7'h23, 16'h003F);
    for (int m = 0; m < 2; m++) begin
      mode = m ? 3'h0 : 3'h5;
      for (int p = 0; p < 3; p++) begin
        u_host.wr(7'h24, 16'h0007 ^ (16'h0001 << p));
        repeat (2) @(negedge clk_sys);
        chk("pulldown", 16'h0001 << p, {13'h0000, pd});
        chk("gates", {10'h000, {2{(m ? 3'h5 : 3'h7) & (3'h7 ^ (3'h1 << p))}}},
          {10'h000, gates});
      end
    end
    en = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("outputs_off", 16'h0000, {7'h00, pd, gates});
    close_out();
  end
  initial begin
    #(5000 * 100);
    errors++;
    close_out();
  end
endmodule // tb

//--- rtl/gdcr_bank.v
// gate drive direct control register bank with gate output stage and source current select
`include "gdcr_regs.vh"

module gdcr_bank #(
  parameter AW = 7, // register address width
  parameter DW = 16, // register data width
  parameter CW = 6 // current code width
) (
  input wire clk_sys, // system clock, 10 MHz
  input wire srst, // synchronous reset, active high
  input wire [AW-1:0] reg_addr, // register address from the serial port decoder
  input wire [DW-1:0] reg_wdata, // register write data
  input wire reg_wr, // write strobe, one cycle
  input wire reg_rd, // read strobe, one cycle
  output reg [DW-1:0] reg_rdata_q, // read data, valid the cycle after reg_rd
  output reg reg_rvalid_q, // read data valid pulse
  input wire global_driver_enable, // driver enable from the control register
  input wire [2:0] pwm_mode, // pwm mode field
  input wire [2:0] pwm_high, // upper gate demand per phase from mode logic, a at bit 2
  input wire [2:0] pwm_low, // lower gate demand per phase from mode logic, a at bit 2
  input wire [CW-1:0] upper_sink_code, // upper sink current code
  input wire [CW-1:0] lower_sink_code, // lower sink current code
  input wire [1:0] upper_ratio, // upper source to sink ratio
  input wire [1:0] lower_ratio, // lower source to sink ratio
  output wire upper_gate_out_a, // phase a upper gate
  output wire upper_gate_out_b, // phase b upper gate
  output wire upper_gate_out_c, // phase c upper gate
  output wire lower_gate_out_a, // phase a lower gate
  output wire lower_gate_out_b, // phase b lower gate
  output wire lower_gate_out_c, // phase c lower gate
  output wire [2:0] phase_pulldown, // active pull-down per phase, a at bit 2
  output reg [CW-1:0] upper_source_code_q, // upper source code in effect
  output reg [CW-1:0] lower_source_code_q, // lower source code in effect
  output reg upper_ratio_used_q, // upper source derived through the ratio
  output reg lower_ratio_used_q, // lower source derived through the ratio
  output reg [1:0] upper_ratio_q, // upper ratio in effect
  output reg [1:0] lower_ratio_q // lower ratio in effect
);
  reg [DW-1:0] direct_q;
  reg [DW-1:0] phen_q;
  reg [DW-1:0] src_q;
  wire direct_mode;
  wire explicit_source_current_sel;
  wire [2:0] force_high;
  wire [2:0] force_low;
  wire [2:0] phase_en;
  wire [2:0] upper_q;
  wire [2:0] lower_q;
  wire [CW-1:0] upper_source_current_code;
  wire [CW-1:0] lower_source_current_code;
  reg [DW-1:0] direct_d;
  reg [DW-1:0] phen_d;
  reg [DW-1:0] src_d;
  reg [DW-1:0] reg_rdata_d;
  wire force_high_gate_a;
  wire force_high_gate_b;
  wire force_high_gate_c;
  wire force_low_gate_a;
  wire force_low_gate_b;
  wire force_low_gate_c;
  wire phase_a_output_enable;
  wire phase_b_output_enable;
  wire phase_c_output_enable;
  reg [CW-1:0] upper_source_code_d;
  reg [CW-1:0] lower_source_code_d;
  reg upper_ratio_used_d;
  reg lower_ratio_used_d;
  reg [1:0] upper_ratio_d;
  reg [1:0] lower_ratio_d;
  genvar g;

  // a sink code above the ratio range is copied as the source code
  function ratio_ok;
    input [CW-1:0] sink;
    begin
      ratio_ok = (sink <= `GDCR_RATIO_MAX_SINK);
    end
  endfunction

  // one write strobe aimed at one mapped address
  function reg_hit;
    input wr;
    input [AW-1:0] addr;
    input [AW-1:0] target;
    begin
      reg_hit = wr && (addr == target);
    end
  endfunction

  function [DW-1:0] reg_read;
    input [AW-1:0] addr;
    begin
      case (addr)
        `GDCR_ADDR_DIRECT: reg_read = direct_q;
        `GDCR_ADDR_PHEN: reg_read = phen_q;
        `GDCR_ADDR_SRC: reg_read = src_q;
        default: reg_read = 16'h0000;
      endcase
    end
  endfunction

  // reserved bits are never stored, so they read back as zero
  always @* begin
    direct_d = direct_q;
    phen_d = phen_q;
    src_d = src_q;
    if (reg_hit(reg_wr, reg_addr, `GDCR_ADDR_DIRECT)) begin
      direct_d = reg_wdata & `GDCR_DIRECT_MASK;
    end
    if (reg_hit(reg_wr, reg_addr, `GDCR_ADDR_PHEN)) begin
      phen_d = reg_wdata & `GDCR_PHEN_MASK;
    end
    if (reg_hit(reg_wr, reg_addr, `GDCR_ADDR_SRC)) begin
      src_d = reg_wdata & `GDCR_SRC_MASK;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      direct_q <= `GDCR_DIRECT_RESET;
      phen_q <= `GDCR_PHEN_RESET;
      src_q <= `GDCR_SRC_RESET;
    end else begin
      direct_q <= direct_d;
      phen_q <= phen_d;
      src_q <= src_d;
    end
  end

  // read data holds until the next read strobe
  always @* begin
    reg_rdata_d = reg_rdata_q;
    if (reg_rd) begin
      reg_rdata_d = reg_read(reg_addr);
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata_q <= 16'h0000;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  assign direct_mode = (pwm_mode == `GDCR_MODE_DIRECT);
  assign force_high_gate_a = direct_q[`GDCR_FORCE_HIGH_LSB+2];
  assign force_high_gate_b = direct_q[`GDCR_FORCE_HIGH_LSB+1];
  assign force_high_gate_c = direct_q[`GDCR_FORCE_HIGH_LSB];
  assign force_low_gate_a = direct_q[`GDCR_FORCE_LOW_LSB+2];
  assign force_low_gate_b = direct_q[`GDCR_FORCE_LOW_LSB+1];
  assign force_low_gate_c = direct_q[`GDCR_FORCE_LOW_LSB];
  assign phase_a_output_enable = phen_q[`GDCR_PHEN_LSB+2];
  assign phase_b_output_enable = phen_q[`GDCR_PHEN_LSB+1];
  assign phase_c_output_enable = phen_q[`GDCR_PHEN_LSB];
  assign force_high = {force_high_gate_a, force_high_gate_b, force_high_gate_c};
  assign force_low = {force_low_gate_a, force_low_gate_b, force_low_gate_c};
  assign phase_en = {phase_a_output_enable, phase_b_output_enable, phase_c_output_enable};
  assign explicit_source_current_sel = direct_q[`GDCR_SRCSEL_BIT];
  assign upper_source_current_code = src_q[`GDCR_UPPER_LSB+CW-1:`GDCR_UPPER_LSB];
  assign lower_source_current_code = src_q[`GDCR_LOWER_LSB+CW-1:`GDCR_LOWER_LSB];

  generate
    for (g = 0; g < 3; g = g + 1) begin : phase
      gdcr_phase u_phase (
        .clk_sys(clk_sys),
        .srst(srst),
        .drv_en(global_driver_enable),
        .direct_mode(direct_mode),
        .force_high(force_high[g]),
        .force_low(force_low[g]),
        .pwm_high(pwm_high[g]),
        .pwm_low(pwm_low[g]),
        .phase_en(phase_en[g]),
        .upper_q(upper_q[g]),
        .lower_q(lower_q[g]),
        .pulldown_q(phase_pulldown[g])
      );
    end
  endgenerate

  assign upper_gate_out_a = upper_q[2];
  assign upper_gate_out_b = upper_q[1];
  assign upper_gate_out_c = upper_q[0];
  assign lower_gate_out_a = lower_q[2];
  assign lower_gate_out_b = lower_q[1];
  assign lower_gate_out_c = lower_q[0];

  // source current selection; the analogue drive scales the sink by the ratio
  always @* begin
    if (explicit_source_current_sel) begin
      upper_source_code_d = upper_source_current_code;
      upper_ratio_used_d = 1'b0;
      upper_ratio_d = 2'h0;
    end else begin
      upper_source_code_d = upper_sink_code;
      upper_ratio_used_d = ratio_ok(upper_sink_code);
      upper_ratio_d = ratio_ok(upper_sink_code) ? upper_ratio : 2'h0;
    end
  end

  always @* begin
    if (explicit_source_current_sel) begin
      lower_source_code_d = lower_source_current_code;
      lower_ratio_used_d = 1'b0;
      lower_ratio_d = 2'h0;
    end else begin
      lower_source_code_d = lower_sink_code;
      lower_ratio_used_d = ratio_ok(lower_sink_code);
      lower_ratio_d = ratio_ok(lower_sink_code) ? lower_ratio : 2'h0;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      upper_source_code_q <= {CW{1'b0}};
      lower_source_code_q <= {CW{1'b0}};
      upper_ratio_used_q <= 1'b0;
      lower_ratio_used_q <= 1'b0;
      upper_ratio_q <= 2'h0;
      lower_ratio_q <= 2'h0;
    end else begin
      upper_source_code_q <= upper_source_code_d;
      lower_source_code_q <= lower_source_code_d;
      upper_ratio_used_q <= upper_ratio_used_d;
      lower_ratio_used_q <= lower_ratio_used_d;
      upper_ratio_q <= upper_ratio_d;
      lower_ratio_q <= lower_ratio_d;
    end
  end
endmodule // gdcr_bank

//--- rtl/gdcr_phase.v
// one phase of the gate output stage: direct drive, mode drive and forced pull-down
module gdcr_phase (
  input wire clk_sys, // system clock
  input wire srst, // synchronous reset, active high
  input wire drv_en, // global driver enable
  input wire direct_mode, // mode field selects direct gate drive
  input wire force_high, // direct drive bit for the upper gate
  input wire force_low, // direct drive bit for the lower gate
  input wire pwm_high, // upper gate demand from the selected pwm mode
  input wire pwm_low, // lower gate demand from the selected pwm mode
  input wire phase_en, // per-phase output enable
  output reg upper_q, // upper gate output
  output reg lower_q, // lower gate output
  output reg pulldown_q // active pull-down engaged on both gates
);
  wire hold_low;
  reg upper_d;
  reg lower_d;

  // pull-down only counts while the driver is enabled; it never touches drv_en
  assign hold_low = drv_en & ~phase_en;

  always @* begin
    if (!drv_en) begin
      upper_d = 1'b0;
      lower_d = 1'b0;
    end else if (hold_low) begin
      upper_d = 1'b0;
      lower_d = 1'b0;
    end else if (direct_mode) begin
      upper_d = force_high;
      lower_d = force_low;
    end else begin
      upper_d = pwm_high;
      lower_d = pwm_low;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      upper_q <= 1'b0;
      lower_q <= 1'b0;
      pulldown_q <= 1'b0;
    end else begin
      upper_q <= upper_d;
      lower_q <= lower_d;
      pulldown_q <= hold_low;
    end
  end
endmodule // gdcr_phase

//--- rtl/gdcr_regs.vh
// register map, field positions and reset values of the gate drive direct control bank
// Function
// - in direct gate mode (mode 101b) the upper gate outputs a, b, c follow register bits 5, 4, 3.
// - in direct gate mode (mode 101b) the lower gate outputs a, b, c follow register bits 2, 1, 0.
// - direct drive bits and phase enables act only while the global driver enable is 1.
// - phase a enable (bit 2) at 0 pulls both phase a gates low at once, no shutdown sequence.
// - phase b enable (bit 1) at 0 pulls both phase b gates low at once, no shutdown sequence.
// - phase c enable (bit 0) at 0 pulls both phase c gates low at once, no shutdown sequence.
// - the per-phase pull-down applies in every mode and overrides the mode's outputs.
// - clearing a phase enable leaves the global driver enable untouched.
// - the phase enables reset to 1, giving normal mode-driven control.
// - the upper source code (bits 13-8) is used only when the explicit source select is 1.
// - the lower source code (bits 5-0) is used only when the explicit source select is 1.
// - with explicit select 0 the source follows the sink through the ratio, or copies high sinks.
`ifndef GDCR_REGS_VH
`define GDCR_REGS_VH

`define GDCR_ADDR_DIRECT 7'h23
`define GDCR_ADDR_PHEN 7'h24
`define GDCR_ADDR_SRC 7'h25

`define GDCR_DIRECT_MASK 16'h023F
`define GDCR_PHEN_MASK 16'h0007
`define GDCR_SRC_MASK 16'h3F3F

`define GDCR_DIRECT_RESET 16'h0000
`define GDCR_PHEN_RESET 16'h0007
`define GDCR_SRC_RESET 16'h0000

`define GDCR_SRCSEL_BIT 9
`define GDCR_UPPER_LSB 8
`define GDCR_LOWER_LSB 0
`define GDCR_FORCE_HIGH_LSB 3
`define GDCR_FORCE_LOW_LSB 0
`define GDCR_PHEN_LSB 0

`define GDCR_MODE_DIRECT 3'h5
`define GDCR_RATIO_MAX_SINK 6'h23

`endif
